// ### rtl/cpr_map.svh
// Register map, field positions and timing counts of the codec port
`ifndef CPR_MAP_SVH
`define CPR_MAP_SVH

// ************************************************************
// Register offsets and masks
// ************************************************************
`define CPR_CTRL0_ADDR 8'h00
`define CPR_CTRL1_ADDR 8'h04
`define CPR_STAT_ADDR 8'h08
`define CPR_CTRL0_MASK 32'h0303_7f7f
`define CPR_CTRL1_MASK 32'h0000_0001
`define CPR_CTRL0_RST 32'h0000_0000
`define CPR_CTRL1_RST 32'h0000_0000

// ************************************************************
// Field positions
// ************************************************************
`define CPR_ASD_LSB 0
`define CPR_TSD_LSB 8
`define CPR_MCE_BIT 16
`define CPR_ECS_BIT 17
`define CPR_ECP_LSB 24
`define CPR_CFS_BIT 0
`define CPR_IN_ENA_BIT 14
`define CPR_OUT_ENA_BIT 15

// ************************************************************
// Codec control addresses and timing counts
// ************************************************************
`define CPR_AUD_CTL_ADDR 4'h4
`define CPR_TEL_CTL_ADDR 4'h2
`define CPR_PRE_LAST 6'h3f
`define CPR_FRAME_LAST 7'h7f
`define CPR_PAD_W 96

`endif

// ### rtl/cpr_pkg.sv
// Types shared by the codec port rate and enable logic
package cpr_pkg;
  typedef enum logic {CPR_IDLE, CPR_RUN} cpr_state_t;
  typedef enum logic [1:0] {CPR_PEND_NONE, CPR_PEND_ON, CPR_PEND_OFF}
    cpr_pend_t;
endpackage

// ### rtl/cpr_clk_src.sv
// Bit-rate source selection and external clock prescaler
`timescale 1ns/100ps
`include "cpr_map.svh"
module cpr_clk_src
  import cpr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic ext_sel,
  input wire logic freq_sel,
  input wire logic [1:0] prescale,
  input wire logic int_lo_edge,
  input wire logic int_hi_edge,
  input wire logic ext_clk_pin,
  output logic src_edge
);

  logic ext_prev_q;
  logic [1:0] div_q;
  logic [1:0] div_d;
  wire ext_edge;
  wire ext_out;
  wire int_edge;

  // ************************************************************
  // Edge selection
  // ************************************************************
  // Every level change of the pin is one edge of the source clock
  assign ext_edge = ext_clk_pin ^ ext_prev_q;
  // Prescaler passes one edge in prescale+1, dividing by 1 to 4
  assign ext_out = ext_edge && (div_q == prescale);
  // Internal rate follows the frequency select bit
  assign int_edge = freq_sel ? int_hi_edge : int_lo_edge;
  // Source clock stops entirely while the port is off
  assign src_edge = enable && (ext_sel ? ext_out : int_edge);
  // Prescaler is held clear while unused or the internal clock runs
  assign div_d = (!enable || !ext_sel) ? 2'h0 :
                 ext_out ? 2'h0 :
                 ext_edge ? div_q + 2'h1 : div_q;

  // Pin history and prescaler state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ext_prev_q <= 1'b0;
      div_q <= 2'h0;
    end else begin
      ext_prev_q <= ext_clk_pin;
      div_q <= div_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  prescale_one_a: assert property (
    enable && ext_sel && prescale == 2'h0 && ext_edge |-> src_edge)
    else $error("prescale 00 dropped an external edge");
  internal_ignore_a: assert property (
    enable && !ext_sel |-> src_edge == int_edge)
    else $error("internal source edge not passed through");
endmodule

// ### rtl/cpr_rate_cnt.sv
// Sample-rate divisor counter with reload and half-duty sample clock
`timescale 1ns/100ps
`include "cpr_map.svh"
module cpr_rate_cnt
  import cpr_pkg::*;
#(
  parameter int W = 7
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic stop,
  input wire logic step,
  input wire logic [W-1:0] modulus,
  output logic running,
  output logic wrap,
  output logic sample_clk,
  output logic [W-1:0] count
);

  logic run_q;
  logic wrap_q;
  logic smp_q;
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire hit;

  // ************************************************************
  // Count and reload
  // ************************************************************
  // Modulus zero is unsupported; it wraps through 127, giving a 128-step period
  assign hit = run_q && step && cnt_q == {{(W-1){1'b0}}, 1'b1};
  // Load on start, reload on the step from one, else step down
  assign cnt_d = start ? modulus :
                 stop ? '0 :
                 hit ? modulus :
                 (run_q && step) ? cnt_q - 1'b1 : cnt_q;
  assign running = run_q;
  assign wrap = wrap_q;
  assign sample_clk = smp_q;
  assign count = cnt_q;

  // Counter, run flag and half-duty output
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      wrap_q <= 1'b0;
      smp_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      run_q <= start || (run_q && !stop);
      wrap_q <= hit && !start && !stop;
      smp_q <= (start || (run_q && !stop)) && cnt_d > (modulus >> 1);
      cnt_q <= cnt_d;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  start_load_a: assert property (
    start |=> count == $past(modulus) && running)
    else $error("counter not loaded with modulus on start");
endmodule

// ### rtl/cpr_port.sv
// Codec port rate pacing, enable control and 128-bit framing
// Function
// - A 7-bit audio divisor sets the audio sample counter modulus.
// - Sample clock is the source clock divided by 32, then the divisor.
// - Clock select 0 uses an internal clock, 1 uses the external pin.
// - A bit in the second control register picks the internal rate.
// - Codec write setting audio enables starts sample clock at frame sync.
// - Codec write clearing both audio enables stops it at frame sync.
// - Running counter steps at the programmed rate, half-duty clock.
// - The enabling codec write loads the next audio transmit sample.
// - At zero the counter reloads, loads the next sample, keeps counting.
// - A telecom divisor and counter work just like the audio ones.
// - Port enable gates everything and wins shared pins over sync port.
// - With pins remapped both serial ports may run together.
// - All port clocks stop while the port is disabled.
// - Reset clears the port enable and sets the frequency select; here reset clears both.
// - Enable starts bit clock; frame sync high one bit, rising with it.
// - While enabled, 128-bit frames follow back to back.
// - Disable stops at once, aborts the frame, releases the pins.
// - Disable flushes FIFOs and keeps the registers as they are.
// - External clock divides by 1 to 4 by prescale; internal ignores it.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "cpr_map.svh"
module cpr_port
  import cpr_pkg::*;
#(
  parameter int DIV_W = 7,
  parameter int SMP_W = 16,
  parameter int FRAME_W = 128
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic ctl_wr,
  input wire logic [3:0] ctl_addr,
  input wire logic [15:0] ctl_data,
  input wire logic [SMP_W-1:0] aud_tx_data,
  input wire logic [SMP_W-1:0] tel_tx_data,
  output logic [1:0] tx_pop,
  output logic fifo_flush,
  input wire logic int_lo_edge,
  input wire logic int_hi_edge,
  input wire logic ext_clk_pin,
  input wire logic ssp_en_req,
  input wire logic alt_pin_remap,
  output logic ssp_granted,
  output logic sclk_o,
  output logic sclk_oe,
  output logic frame_sync_pin_o,
  output logic frame_sync_pin_oe,
  output logic txd_o,
  output logic txd_oe,
  input wire logic rxd_i,
  output logic [FRAME_W-1:0] rx_frame,
  output logic rx_strobe,
  output logic aud_sample_clk,
  output logic tel_sample_clk
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [31:0] ctrl0_q;
  logic [31:0] ctrl1_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  cpr_state_t state_q;
  cpr_state_t state_d;
  logic sclk_q;
  logic frame_sync_pin_q;
  logic [6:0] bit_q;
  logic [5:0] pre_q;
  logic [FRAME_W-1:0] tx_sh_q;
  logic [FRAME_W-1:0] rx_sh_q;
  logic [FRAME_W-1:0] rx_frame_q;
  logic rx_strobe_q;
  logic [FRAME_W-1:0] frame_w;
  logic [FRAME_W-1:0] rx_next;
  cpr_pend_t pend_q [2];
  logic [SMP_W-1:0] field_q [2];
  logic [SMP_W-1:0] tx_data [2];
  logic [DIV_W-1:0] div_w [2];
  logic [DIV_W-1:0] cnt_w [2];
  logic [1:0] ena_wr;
  logic [1:0] ch_start;
  logic [1:0] ch_stop;
  logic [1:0] ch_run;
  logic [1:0] ch_wrap;
  logic [1:0] ch_smp;
  wire port_on;
  wire run_w;
  wire edge_w;
  wire rise_w;
  wire fall_w;
  wire fs_rise;
  wire pre_tick;
  wire wr_ctrl0;
  wire wr_ctrl1;
  wire any_ena;

  // Codec control register that enables each channel
  function automatic logic [3:0] ctl_reg_of(input int ch);
    return (ch == 0) ? `CPR_AUD_CTL_ADDR : `CPR_TEL_CTL_ADDR;
  endfunction

  // ************************************************************
  // Register bus
  // ************************************************************
  // Write decode; reserved bits are masked off and read back zero
  assign wr_ctrl0 = reg_wr && reg_addr == `CPR_CTRL0_ADDR;
  assign wr_ctrl1 = reg_wr && reg_addr == `CPR_CTRL1_ADDR;
  assign port_on = ctrl0_q[`CPR_MCE_BIT];
  assign div_w[0] = ctrl0_q[`CPR_ASD_LSB +: DIV_W];
  assign div_w[1] = ctrl0_q[`CPR_TSD_LSB +: DIV_W];
  // Read mux; unmapped offsets answer zero
  assign rdata_d = (reg_addr == `CPR_CTRL0_ADDR) ? ctrl0_q :
                   (reg_addr == `CPR_CTRL1_ADDR) ? ctrl1_q :
                   (reg_addr == `CPR_STAT_ADDR) ?
                     {9'h0, cnt_w[1], 1'h0, cnt_w[0], 4'h0,
                      ssp_granted, ch_run[1], ch_run[0], run_w} :
                   32'h0000_0000;
  assign reg_rdata = rdata_q;

  // Control registers survive disable; only reset clears them
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0_q <= `CPR_CTRL0_RST;
      ctrl1_q <= `CPR_CTRL1_RST;
      rdata_q <= 32'h0000_0000;
    end else begin
      if (wr_ctrl0) begin
        ctrl0_q <= reg_wdata & `CPR_CTRL0_MASK;
      end
      if (wr_ctrl1) begin
        ctrl1_q <= reg_wdata & `CPR_CTRL1_MASK;
      end
      rdata_q <= reg_rd ? rdata_d : 32'h0000_0000;
    end
  end

  // ************************************************************
  // Port state and pin ownership
  // ************************************************************
  // Port runs from the cycle after the enable bit is seen set
  assign state_d = port_on ? CPR_RUN : CPR_IDLE;
  assign run_w = state_q == CPR_RUN && port_on;
  // Disable flushes the FIFOs in the cycle it is seen
  assign fifo_flush = state_q == CPR_RUN && !port_on;
  // This port owns the shared pins while enabled unless the sync port is remapped
  assign ssp_granted = ssp_en_req && (!port_on || alt_pin_remap);
  // Pins are driven only while running, released at once otherwise
  assign sclk_oe = run_w;
  assign frame_sync_pin_oe = run_w;
  assign txd_oe = run_w;
  assign sclk_o = sclk_q;
  assign frame_sync_pin_o = frame_sync_pin_q;
  assign txd_o = tx_sh_q[FRAME_W-1];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CPR_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // Bit clock source
  // ************************************************************
  cpr_clk_src u_clk_src (
    .clock(clock),
    .rst_n(rst_n),
    .enable(run_w),
    .ext_sel(ctrl0_q[`CPR_ECS_BIT]),
    .freq_sel(ctrl1_q[`CPR_CFS_BIT]),
    .prescale(ctrl0_q[`CPR_ECP_LSB +: 2]),
    .int_lo_edge(int_lo_edge),
    .int_hi_edge(int_hi_edge),
    .ext_clk_pin(ext_clk_pin),
    .src_edge(edge_w)
  );

  // ************************************************************
  // Framing
  // ************************************************************
  // Each source edge toggles the bit clock; rising edges advance bits
  assign rise_w = run_w && edge_w && !sclk_q;
  assign fall_w = run_w && edge_w && sclk_q;
  // Frame sync rises with the bit clock on bit zero of each frame
  assign fs_rise = rise_w && bit_q == `CPR_FRAME_LAST;
  // Outgoing frame carries both sample fields, the rest is zero
  assign frame_w = {field_q[0], field_q[1], {`CPR_PAD_W{1'b0}}};
  assign rx_next = {rx_sh_q[FRAME_W-2:0], rxd_i};
  assign rx_frame = rx_frame_q;
  assign rx_strobe = rx_strobe_q;

  // Bit clock, frame sync and bit position
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
      frame_sync_pin_q <= 1'b0;
      bit_q <= `CPR_FRAME_LAST;
    end else if (!run_w) begin
      sclk_q <= 1'b0;
      frame_sync_pin_q <= 1'b0;
      bit_q <= `CPR_FRAME_LAST;
    end else if (edge_w) begin
      sclk_q <= !sclk_q;
      if (rise_w) begin
        frame_sync_pin_q <= fs_rise;
        bit_q <= bit_q + 7'h01;
      end
    end
  end

  // Transmit shifter loads a new frame at each frame sync
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_q <= '0;
    end else if (!run_w) begin
      tx_sh_q <= '0;
    end else if (fs_rise) begin
      tx_sh_q <= frame_w;
    end else if (rise_w) begin
      tx_sh_q <= {tx_sh_q[FRAME_W-2:0], 1'b0};
    end
  end

  // Receive shifter samples on falling bit clock, hands over whole frames
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh_q <= '0;
      rx_frame_q <= '0;
      rx_strobe_q <= 1'b0;
    end else begin
      rx_strobe_q <= fall_w && bit_q == `CPR_FRAME_LAST;
      if (fall_w) begin
        rx_sh_q <= rx_next;
      end
      if (fall_w && bit_q == `CPR_FRAME_LAST) begin
        rx_frame_q <= rx_next;
      end
    end
  end

  // ************************************************************
  // Fixed divide by 32 of the source clock
  // ************************************************************
  // Thirty-two source periods are sixty-four source edges
  assign pre_tick = run_w && edge_w && pre_q == `CPR_PRE_LAST;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 6'h00;
    end else if (!run_w) begin
      pre_q <= 6'h00;
    end else if (edge_w) begin
      pre_q <= pre_q + 6'h01;
    end
  end

  // ************************************************************
  // Audio and telecom channels
  // ************************************************************
  assign tx_data[0] = aud_tx_data;
  assign tx_data[1] = tel_tx_data;
  assign any_ena = ctl_data[`CPR_IN_ENA_BIT] || ctl_data[`CPR_OUT_ENA_BIT];
  assign aud_sample_clk = ch_smp[0];
  assign tel_sample_clk = ch_smp[1];

  for (genvar g = 0; g < 2; g++) begin : g_ch
    wire hit_w;
    cpr_pend_t pend_d;

    // Enable writes wait for the next frame sync to take effect
    assign hit_w = run_w && ctl_wr && ctl_addr == ctl_reg_of(g);
    assign ena_wr[g] = hit_w && any_ena;
    assign pend_d = hit_w ? (any_ena ? CPR_PEND_ON : CPR_PEND_OFF) :
                    fs_rise ? CPR_PEND_NONE : pend_q[g];
    assign ch_start[g] = fs_rise && pend_q[g] == CPR_PEND_ON;
    assign ch_stop[g] = (fs_rise && pend_q[g] == CPR_PEND_OFF) ||
                        !run_w;
    // Sample pops on the enabling write and on each reload
    assign tx_pop[g] = ena_wr[g] || (run_w && ch_wrap[g]);

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        pend_q[g] <= CPR_PEND_NONE;
        field_q[g] <= '0;
      end else begin
        pend_q[g] <= run_w ? pend_d : CPR_PEND_NONE;
        if (tx_pop[g]) begin
          field_q[g] <= tx_data[g];
        end
      end
    end

    // Divisor matches the codec's own so both count in lock-step
    cpr_rate_cnt #(.W(DIV_W)) u_rate (
      .clock(clock),
      .rst_n(rst_n),
      .start(ch_start[g]),
      .stop(ch_stop[g]),
      .step(pre_tick),
      .modulus(div_w[g]),
      .running(ch_run[g]),
      .wrap(ch_wrap[g]),
      .sample_clk(ch_smp[g]),
      .count(cnt_w[g])
    );
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence frame_end_s;
    rise_w && bit_q == `CPR_FRAME_LAST;
  endsequence

  sequence frame_open_s;
    bit_q == 7'h00 && frame_sync_pin_q && sclk_q;
  endsequence

  sync_with_sclk_a: assert property (
    $rose(frame_sync_pin_q) |-> $rose(sclk_q))
    else $error("frame sync rose without the bit clock");
  frame_wrap_a: assert property (
    frame_end_s |=> frame_open_s)
    else $error("frame did not restart after bit 127");
  sync_one_bit_a: assert property (
    frame_sync_pin_q && rise_w |=> !frame_sync_pin_q)
    else $error("frame sync held past one bit period");
  disable_release_a: assert property (
    port_on ##1 !port_on |-> !sclk_oe && !txd_oe && !frame_sync_pin_oe
      ##1 !sclk_q && bit_q == `CPR_FRAME_LAST)
    else $error("pins or frame not released on disable");
  disable_flush_a: assert property (
    state_q == CPR_RUN && !port_on |-> fifo_flush ##1 !fifo_flush)
    else $error("disable did not flush the FIFOs once");
  ssp_priority_a: assert property (
    ssp_en_req && port_on && !alt_pin_remap |-> !ssp_granted)
    else $error("sync port granted shared pins while port on");
  ssp_remap_a: assert property (
    ssp_en_req && alt_pin_remap |-> ssp_granted)
    else $error("remapped sync port not granted");
  clocks_off_a: assert property (
    !run_w |-> !edge_w && !pre_tick ##1 !sclk_q)
    else $error("port clock active while disabled");
  start_at_sync_a: assert property (
    pend_q[0] == CPR_PEND_ON && fs_rise |=> ch_run[0])
    else $error("audio sample clock did not start at frame sync");
  stop_at_sync_a: assert property (
    pend_q[0] == CPR_PEND_OFF && fs_rise |=> !ch_run[0])
    else $error("audio sample clock did not stop at frame sync");
  enable_load_a: assert property (
    ena_wr[0] |-> tx_pop[0] ##1 field_q[0] == $past(aud_tx_data))
    else $error("enabling write did not load an audio sample");
  reload_load_a: assert property (
    run_w && ch_wrap[1] |-> tx_pop[1] ##1 field_q[1] == $past(tel_tx_data))
    else $error("telecom reload did not load a sample");
  reset_off_a: assert property (
    $rose(rst_n) |-> !port_on && !ctrl1_q[`CPR_CFS_BIT])
    else $error("port enable or frequency select not reset");
endmodule

// ### test/cpr_codec_model.sv
// Behavioural codec chip on the far side of the serial port
`timescale 1ns/100ps
module cpr_codec_model #(
  parameter logic [127:0] RX_PAT = 128'h0
) (
  input wire logic sclk,
  input wire logic frame_sync_pin,
  input wire logic txd,
  input wire logic active,
  output logic rxd,
  output logic [127:0] tx_seen
);
  int idx = 0;
  logic [127:0] sh = '0;
  initial rxd = 1'b0;
  initial tx_seen = '0;
  // ************************************************************
  // Receive stream and transmit capture
  // ************************************************************
  // Next receive bit goes out just after each bit clock rise
  always @(posedge sclk) begin
    #1;
    if (frame_sync_pin) begin
      idx = 0;
      tx_seen <= sh;
    end else begin
      idx = idx + 1;
    end
    if (idx < 128) begin
      rxd <= RX_PAT[127 - idx];
    end
  end
  // Transmit bits are taken on the falling bit clock edge
  always @(negedge sclk) sh = {sh[126:0], txd};
  // A released line must not keep showing the last bit
  always @(negedge active) rxd <= ~rxd;
endmodule

// ### test/test_cpr_port.sv
// Self-checking bench for the codec port rate and enable logic
`timescale 1ns/100ps
`include "cpr_map.svh"
module test_cpr_port;
  localparam logic [127:0] PAT = 128'h8123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978;
  logic clock, rst_n, reg_wr, reg_rd, ctl_wr, int_lo_edge, int_hi_edge;
  logic ext_clk_pin, ssp_en_req, alt_pin_remap, rxd_i, fifo_flush;
  logic ssp_granted, sclk_o, sclk_oe, frame_sync_pin_o, frame_sync_pin_oe, txd_o, txd_oe;
  logic rx_strobe, aud_sample_clk, tel_sample_clk;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_v;
  logic [3:0] ctl_addr;
  logic [15:0] ctl_data, aud_tx_data, tel_tx_data;
  logic [1:0] tx_pop, pop_v;
  logic [127:0] rx_frame, tx_seen;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  int pops[2] = '{0, 0};
  int t, hi, p0, s0, strb;
  int ecs_t[6] = '{1, 1, 1, 1, 0, 0};
  int ecp_t[6] = '{0, 1, 2, 3, 0, 0};
  int fs_t[6] = '{0, 0, 0, 0, 1, 0};
  int per_t[6] = '{2, 4, 6, 8, 3, 4};

  cpr_port uut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ctl_wr(ctl_wr), .ctl_addr(ctl_addr),
    .ctl_data(ctl_data), .aud_tx_data(aud_tx_data),
    .tel_tx_data(tel_tx_data), .tx_pop(tx_pop), .fifo_flush(fifo_flush),
    .int_lo_edge(int_lo_edge), .int_hi_edge(int_hi_edge),
    .ext_clk_pin(ext_clk_pin), .ssp_en_req(ssp_en_req),
    .alt_pin_remap(alt_pin_remap), .ssp_granted(ssp_granted),
    .sclk_o(sclk_o), .sclk_oe(sclk_oe), .frame_sync_pin_o(frame_sync_pin_o), .frame_sync_pin_oe(frame_sync_pin_oe),
    .txd_o(txd_o), .txd_oe(txd_oe), .rxd_i(rxd_i), .rx_frame(rx_frame),
    .rx_strobe(rx_strobe), .aud_sample_clk(aud_sample_clk),
    .tel_sample_clk(tel_sample_clk));
  cpr_codec_model #(.RX_PAT(PAT)) codec (.sclk(sclk_o), .frame_sync_pin(frame_sync_pin_o),
    .txd(txd_o), .active(frame_sync_pin_oe), .rxd(rxd_i), .tx_seen(tx_seen));

  // ************************************************************
  // Clock, source edges and pop counting
  // ************************************************************
  // Clock at 200 MHz
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Low source every 4 clocks, high every 3, pin toggles every 2
  always @(posedge clock) begin
    cyc <= cyc + 1;
    int_lo_edge <= (cyc % 4 == 0);
    int_hi_edge <= (cyc % 3 == 0);
    ext_clk_pin <= cyc[1];
  end
  // Count sample loads and frame hand-overs as each edge samples them
  always @(posedge clock) begin
    if (tx_pop[0] === 1'b1) pops[0]++;
    if (tx_pop[1] === 1'b1) pops[1]++;
    if (rx_strobe === 1'b1) strb++;
  end

  // ************************************************************
  // Bus tasks and helpers
  // ************************************************************
  task check(input string name, input logic [127:0] seen,
             input logic [127:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    rd_v = reg_rdata;
  endtask
  // Codec control write; the pop is looked at in its own cycle
  task cw(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    ctl_addr <= a;
    ctl_data <= d;
    ctl_wr <= 1'b1;
    @(negedge clock);
    pop_v = tx_pop;
    @(posedge clock);
    ctl_wr <= 1'b0;
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0: return frame_sync_pin_o;
      1: return aud_sample_clk;
      default: return tel_sample_clk;
    endcase
  endfunction
  // Cycles to the next rise of a signal, and its high cycles meanwhile
  task wait_rise(input int sel);
    logic prev, cur;
    prev = pick(sel);
    t = 0;
    hi = 0;
    repeat (20000) begin
      @(negedge clock);
      cur = pick(sel);
      t++;
      if (cur) hi++;
      if (cur && !prev) return;
      prev = cur;
    end
    check("edge wait", 0, 1);
  endtask
  // Control word with audio divisor 4 and telecom divisor 6
  function automatic logic [31:0] ctl0(input int on, external_clock_select, external_clock_prescale);
    return {6'h0, external_clock_prescale[1:0], 6'h0, external_clock_select[0], on[0], 8'h06, 8'h04};
  endfunction
  // Start a channel, time its sample clock, then stop it
  task chan(input int ch, input logic [3:0] a, input int m);
    cw(a, 16'h8000 >> (ch - 1));
    check("pop", pop_v[ch-1], 1);
    rd(`CPR_STAT_ADDR);
    check("pending", rd_v[ch], 0);
    wait_rise(0);
    rd(`CPR_STAT_ADDR);
    check("started", rd_v[ch], 1);
    check("loaded", rd_v[8*ch+6 -: 7], m);
    wait_rise(ch);
    p0 = pops[ch-1];
    wait_rise(ch);
    check("period", t, 64 * m * 4);
    check("duty", hi, 32 * m * 4);
    check("reload", pops[ch-1] - p0, 1);
    check("field", tx_seen[143-16*ch -: 16],
          ch == 1 ? aud_tx_data : tel_tx_data);
    check("pad", tx_seen[95:0], 0);
    cw(a, 16'h0000);
    rd(`CPR_STAT_ADDR);
    check("stop pending", rd_v[ch], 1);
    wait_rise(0);
    rd(`CPR_STAT_ADDR);
    check("stopped", rd_v[ch], 0);
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ************************************************************
  // Test sequence and watchdog
  // ************************************************************
  initial begin
    {rst_n, reg_wr, reg_rd, ctl_wr, int_lo_edge, int_hi_edge} = '0;
    {reg_addr, reg_wdata, ctl_addr, ctl_data, ext_clk_pin} = '0;
    {alt_pin_remap, ssp_en_req} = 2'b01;
    aud_tx_data = 16'h5a3c;
    tel_tx_data = 16'hc3a5;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    rd(`CPR_CTRL0_ADDR);
    check("ctrl0 reset", rd_v, `CPR_CTRL0_RST);
    rd(`CPR_CTRL1_ADDR);
    check("ctrl1 reset", rd_v, `CPR_CTRL1_RST);
    check("oe idle", {sclk_oe, frame_sync_pin_oe, txd_oe}, 0);
    rd(8'h0c);
    check("unmapped", rd_v, 0);
    wr(`CPR_CTRL0_ADDR, 32'hfffe_ffff);
    rd(`CPR_CTRL0_ADDR);
    check("ctrl0 rw", rd_v, 32'hfffe_ffff & `CPR_CTRL0_MASK);
    wr(`CPR_CTRL1_ADDR, 32'hffff_ffff);
    rd(`CPR_CTRL1_ADDR);
    check("ctrl1 rw", rd_v, `CPR_CTRL1_MASK);
    wr(`CPR_STAT_ADDR, 32'hffff_ffff);
    rd(`CPR_STAT_ADDR);
    check("status", rd_v, 32'h8);
    for (int i = 0; i < 6; i++) begin
      wr(`CPR_CTRL0_ADDR, ctl0(0, ecs_t[i], ecp_t[i]));
      wr(`CPR_CTRL1_ADDR, fs_t[i]);
      wr(`CPR_CTRL0_ADDR, ctl0(1, ecs_t[i], ecp_t[i]));
      // Port state turns to running one cycle after the bit is seen
      repeat (2) @(negedge clock);
      check("oe on", {sclk_oe, frame_sync_pin_oe}, 2'b11);
      wait_rise(0);
      check("sclk with sync", sclk_o, 1);
      s0 = strb;
      wait_rise(0);
      check("frame len", t, 256 * per_t[i]);
      check("rx strobe", strb - s0, 1);
      check("sync width", hi, 2 * per_t[i]);
    end
    check("rx frame", rx_frame, PAT);
    chan(1, `CPR_AUD_CTL_ADDR, 4);
    chan(2, `CPR_TEL_CTL_ADDR, 6);
    @(negedge clock);
    check("ssp shared", ssp_granted, 0);
    @(posedge clock);
    alt_pin_remap <= 1'b1;
    @(negedge clock);
    check("ssp remap", ssp_granted, 1);
    wr(`CPR_CTRL0_ADDR, ctl0(0, 0, 0));
    @(negedge clock);
    check("flush", fifo_flush, 1);
    check("oe off", {sclk_oe, frame_sync_pin_oe, txd_oe}, 0);
    repeat (20) @(negedge clock);
    check("clocks idle", {sclk_o, frame_sync_pin_o, aud_sample_clk}, 0);
    rd(`CPR_CTRL0_ADDR);
    check("ctrl0 kept", rd_v, ctl0(0, 0, 0));
    give_verdict;
  end
  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    give_verdict;
  end
endmodule
